// File: rtl/icu_pkg.sv
// Constants, register map, field layout and carrier types of the poll/EOI logic.
// Assumes a single 50 MHz clock and a plain strobe-based register port.
// ****************************************************************
// Register map and fields
// ****************************************************************
package icu_pkg;

	localparam int          NSRC         = 7;
	localparam int          SRC_W        = 3;
	localparam int          DATA_W       = 16;
	localparam int          ADDR_W       = 4;
	localparam int          TYPE_W       = 5;
	localparam int          EV_W         = 4;

	// Register word indices
	localparam logic [3:0]  ADDR_POLL    = 4'h0;
	localparam logic [3:0]  ADDR_POLLSTS = 4'h1;
	localparam logic [3:0]  ADDR_EOS     = 4'h2;
	localparam logic [3:0]  ADDR_REQST   = 4'h3;
	localparam logic [3:0]  ADDR_INSERV  = 4'h4;
	localparam logic [3:0]  ADDR_MASK    = 4'h5;
	localparam logic [3:0]  ADDR_PRIMSK  = 4'h6;
	localparam logic [3:0]  ADDR_INTSTS  = 4'h7;
	localparam logic [3:0]  ADDR_EVSTS   = 4'h8;
	localparam logic [3:0]  ADDR_EVMASK  = 4'h9;

	// Field positions
	localparam int          POLL_PEND_BIT = 15;
	localparam int          EOS_NONSPEC_BIT = 15;
	localparam int          STS_TMR_LSB   = 0;
	localparam int          STS_SER_LSB   = 3;
	localparam int          STS_NMI_BIT   = 15;

	// Reset values
	localparam logic [2:0]  PM_RESET     = 3'h7;
	localparam logic [6:0]  MASK_RESET   = 7'h7F;

	// Source indices, fixed priority: lower index wins
	localparam logic [2:0]  SRC_TMR      = 3'h0;
	localparam logic [2:0]  SRC_SER      = 3'h1;
	localparam logic [2:0]  SRC_DIR_E    = 3'h2;

	// Interrupt types
	localparam logic [4:0]  TYPE_TMR     = 5'h08;
	localparam logic [4:0]  TYPE_SER     = 5'h14;
	localparam logic [4:0]  TYPE_DIR_E   = 5'h11;
	localparam logic [4:0]  TYPE_CASC_A  = 5'h0C;

	// Event bits of the event status register
	localparam int          EV_POLL_ACK  = 0;
	localparam int          EV_EOS       = 1;
	localparam int          EV_EOS_IDLE  = 2;
	localparam int          EV_PEND      = 3;

	typedef struct packed {
		logic                  wr;
		logic                  rd;
		logic [ADDR_W-1:0]     addr;
		logic [DATA_W-1:0]     wdata;
	} icu_bus_t;

	typedef struct packed {
		logic                  pend;
		logic [TYPE_W-1:0]     vtype;
	} icu_poll_t;

	// Interrupt type of a source index
	function automatic logic [4:0] src_type(input logic [2:0] idx);
		case (idx)
			SRC_TMR:  src_type = TYPE_TMR;
			SRC_SER:  src_type = TYPE_SER;
			SRC_DIR_E: src_type = TYPE_DIR_E;
			default:   src_type = TYPE_CASC_A + {2'h0, idx - 3'h3};
		endcase
	endfunction : src_type

endpackage : icu_pkg

// File: rtl/icu_pri_enc.sv
// Fixed priority encoder: lowest set bit wins.
// Assumes a purely combinational use inside the poll/EOI block.
`timescale 1ns/1ps
`default_nettype none
module icu_pri_enc (
	input  wire logic [6:0] vec_i,
	output logic            valid_o,
	output logic [2:0]      idx_o
);
	always_comb begin
		idx_o = 3'h0;
		for (int i = 6; i >= 0; i--) begin
			if (vec_i[i]) begin
				idx_o = 3'(i);
			end
		end
	end

	assign valid_o = |vec_i;
endmodule : icu_pri_enc
`default_nettype wire

// File: rtl/icu_evt_irq.sv
// Sticky event status, mask and level interrupt output.
// Assumes write strobes from the register decoder on the same clock.
`timescale 1ns/1ps
`default_nettype none
module icu_evt_irq (
	input  wire logic       clk_i,
	input  wire logic       rst_n_i,
	input  wire logic [3:0] evt_i,
	input  wire logic       wr_sts_i,
	input  wire logic       wr_mask_i,
	input  wire logic [3:0] wdata_i,
	output logic [3:0]      sts_o,
	output logic [3:0]      mask_o,
	output logic            irq_o
);
	logic [3:0] sts_reg;
	logic [3:0] sts_next;
	logic [3:0] mask_reg;
	logic       irq_reg;

	// A new event beats a write-one-to-clear in the same cycle
	assign sts_next = (sts_reg & ~(wr_sts_i ? wdata_i : 4'h0)) | evt_i;

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			sts_reg  <= 4'h0;
			mask_reg <= 4'h0;
			irq_reg  <= 1'b0;
		end else begin
			sts_reg  <= sts_next;
			if (wr_mask_i) begin
				mask_reg <= wdata_i;
			end
			irq_reg  <= |(sts_next & (wr_mask_i ? wdata_i : mask_reg));
		end
	end

	assign sts_o  = sts_reg;
	assign mask_o = mask_reg;
	assign irq_o  = irq_reg;
endmodule : icu_evt_irq
`default_nettype wire

// File: rtl/icu_poll_eoi.sv
// Poll, poll status, end-of-service and interrupt status logic.
// Assumes same-clock request pulses from the source logic and a
// core that runs the vectoring handshake through hw_ack_i.
//
// Our own choices: the strobed register port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module icu_poll_eoi (
	input  wire logic             clk_i,
	input  wire logic             rst_n_i,
	input  wire icu_pkg::icu_bus_t bus_i,
	output logic [15:0]           rdata_o,
	input  wire logic [4:0]       ext_req_i,
	input  wire logic [2:0]       tmr_evt_i,
	input  wire logic [1:0]       ser_evt_i,
	input  wire logic             nmi_i,
	input  wire logic             nmi_ack_i,
	input  wire logic             hw_ack_i,
	output logic                  int_pend_o,
	output logic                  ack_valid_o,
	output logic [4:0]            ack_type_o,
	output logic                  irq_o
);

	// ****************************************************************
	// State
	// ****************************************************************
	logic [6:0]  req_reg;
	logic [6:0]  req_next;
	logic [6:0]  ins_reg;
	logic [6:0]  ins_next;
	logic [6:0]  mask_reg;
	logic [2:0]  pm_reg;
	logic [15:0] sts_reg;
	logic [15:0] sts_next;
	logic [15:0] rdata_reg;
	logic        ack_valid_reg;
	logic [4:0]  ack_type_reg;
	logic        pend_q_reg;
	logic        nmi_s1_reg;
	logic        nmi_s2_reg;
	logic        nmi_s3_reg;

	// ****************************************************************
	// Helpers
	// ****************************************************************
	// Lowest set bit of a vector, as a one-hot mask
	function automatic logic [15:0] first_bit(input logic [15:0] v);
		first_bit = v & (~v + 16'h0001);
	endfunction : first_bit

	// Source index of an interrupt type; valid flag low if none matches
	function automatic logic [3:0] type_to_src(input logic [4:0] t);
		type_to_src = 4'h0;
		for (int i = 0; i < icu_pkg::NSRC; i++) begin
			if (icu_pkg::src_type(3'(i)) == t) begin
				type_to_src = {1'b1, 3'(i)};
			end
		end
	endfunction : type_to_src

	// ****************************************************************
	// Register decode
	// ****************************************************************
	wire wr_eos    = bus_i.wr && bus_i.addr == icu_pkg::ADDR_EOS;
	wire wr_mask   = bus_i.wr && bus_i.addr == icu_pkg::ADDR_MASK;
	wire wr_pm     = bus_i.wr && bus_i.addr == icu_pkg::ADDR_PRIMSK;
	wire wr_evsts  = bus_i.wr && bus_i.addr == icu_pkg::ADDR_EVSTS;
	wire wr_evmask = bus_i.wr && bus_i.addr == icu_pkg::ADDR_EVMASK;
	wire rd_poll   = bus_i.rd && bus_i.addr == icu_pkg::ADDR_POLL;

	// ****************************************************************
	// Request set and pending resolution
	// ****************************************************************
	// Requests land whether masked or not
	wire [6:0] req_set = {ext_req_i, |ser_evt_i, |tmr_evt_i};

	wire       ins_valid;
	wire [2:0] ins_idx;
	wire       pend_valid;
	wire [2:0] pend_idx;
	logic [6:0] elig;

	// Eligible: unmasked, within threshold, above anything in service
	always_comb begin
		for (int i = 0; i < icu_pkg::NSRC; i++) begin
			elig[i] = req_reg[i] && !mask_reg[i] && 3'(i) <= pm_reg &&
				(!ins_valid || 3'(i) < ins_idx);
		end
	end

	icu_pri_enc u_ins_enc (
		.vec_i   (ins_reg),
		.valid_o (ins_valid),
		.idx_o   (ins_idx)
	);

	icu_pri_enc u_pend_enc (
		.vec_i   (elig),
		.valid_o (pend_valid),
		.idx_o   (pend_idx)
	);

	// ****************************************************************
	// Poll word
	// ****************************************************************
	icu_pkg::icu_poll_t poll_word;
	assign poll_word.pend  = pend_valid;
	assign poll_word.vtype = pend_valid ? icu_pkg::src_type(pend_idx) : 5'h00;

	wire [15:0] poll_data = {poll_word.pend, 10'h000, poll_word.vtype};

	// ****************************************************************
	// Acknowledge
	// ****************************************************************
	// A poll read takes the acknowledge; a hardware one in the same
	// cycle is dropped, the core retries only if int_pend_o is still up.
	wire poll_ack = rd_poll && pend_valid;
	wire hw_take  = hw_ack_i && pend_valid && !rd_poll;
	wire ack_fire = poll_ack || hw_take;
	wire [6:0] ack_hot = ack_fire ? 7'h01 << pend_idx : 7'h00;

	// ****************************************************************
	// End of service
	// ****************************************************************
	wire       eos_nonspec = bus_i.wdata[icu_pkg::EOS_NONSPEC_BIT];
	wire [3:0] eos_match   = type_to_src(bus_i.wdata[icu_pkg::TYPE_W-1:0]);
	logic [6:0] eos_clr;

	// An unknown specific type clears nothing
	always_comb begin
		eos_clr = 7'h00;
		if (wr_eos) begin
			if (eos_nonspec) begin
				// Empty in-service leaves the mask at zero
				eos_clr = ins_valid ? 7'h01 << ins_idx : 7'h00;
			end else if (eos_match[3]) begin
				// Type 8 maps to the one timer bit
				eos_clr = 7'h01 << eos_match[2:0];
			end
		end
	end

	// Acknowledge beats a clear of the same bit
	assign ins_next = (ins_reg & ~eos_clr) | ack_hot;
	assign req_next = (req_reg & ~ack_hot) | req_set;

	// ****************************************************************
	// Interrupt status register
	// ****************************************************************
	wire        nmi_rise = nmi_s2_reg && !nmi_s3_reg;
	wire [15:0] sts_tmr_m = 16'h0007 << icu_pkg::STS_TMR_LSB;
	wire [15:0] sts_ser_m = 16'h0003 << icu_pkg::STS_SER_LSB;
	wire [15:0] sts_nmi_m = 16'h0001 << icu_pkg::STS_NMI_BIT;
	wire [15:0] sts_set;
	logic [15:0] sts_clr;

	// Every bit sets on its own, no exclusion between them
	assign sts_set = ({13'h0000, tmr_evt_i} << icu_pkg::STS_TMR_LSB) |
		({14'h0000, ser_evt_i} << icu_pkg::STS_SER_LSB) |
		(nmi_rise ? sts_nmi_m : 16'h0000);

	// Acknowledge of a shared source retires its lowest-numbered sub-bit
	always_comb begin
		sts_clr = 16'h0000;
		if (ack_fire && pend_idx == icu_pkg::SRC_TMR) begin
			sts_clr = first_bit(sts_reg & sts_tmr_m);
		end else if (ack_fire && pend_idx == icu_pkg::SRC_SER) begin
			sts_clr = first_bit(sts_reg & sts_ser_m);
		end
		if (nmi_ack_i) begin
			sts_clr = sts_clr | sts_nmi_m;
		end
	end

	assign sts_next = (sts_reg & ~sts_clr) | sts_set;

	// ****************************************************************
	// Event interrupt
	// ****************************************************************
	wire [3:0] evt;
	wire [3:0] ev_sts;
	wire [3:0] ev_mask;

	assign evt[icu_pkg::EV_POLL_ACK] = poll_ack;
	assign evt[icu_pkg::EV_EOS]      = |eos_clr;
	assign evt[icu_pkg::EV_EOS_IDLE] = wr_eos && eos_nonspec && !ins_valid;
	assign evt[icu_pkg::EV_PEND]     = pend_valid && !pend_q_reg;

	icu_evt_irq u_evt_irq (
		.clk_i     (clk_i),
		.rst_n_i   (rst_n_i),
		.evt_i     (evt),
		.wr_sts_i  (wr_evsts),
		.wr_mask_i (wr_evmask),
		.wdata_i   (bus_i.wdata[3:0]),
		.sts_o     (ev_sts),
		.mask_o    (ev_mask),
		.irq_o     (irq_o)
	);

	// ****************************************************************
	// Read mux
	// ****************************************************************
	logic [15:0] rd_mux;

	// Both poll words come from one source; only a read at ADDR_POLL takes the acknowledge
	always_comb begin
		case (bus_i.addr)
			icu_pkg::ADDR_POLL:    rd_mux = poll_data;
			icu_pkg::ADDR_POLLSTS: rd_mux = poll_data;
			icu_pkg::ADDR_REQST:   rd_mux = {9'h000, req_reg};
			icu_pkg::ADDR_INSERV:  rd_mux = {9'h000, ins_reg};
			icu_pkg::ADDR_MASK:    rd_mux = {9'h000, mask_reg};
			icu_pkg::ADDR_PRIMSK:  rd_mux = {13'h0000, pm_reg};
			icu_pkg::ADDR_INTSTS:  rd_mux = sts_reg;
			icu_pkg::ADDR_EVSTS:   rd_mux = {12'h000, ev_sts};
			icu_pkg::ADDR_EVMASK:  rd_mux = {12'h000, ev_mask};
			default:               rd_mux = 16'h0000;
		endcase
	end

	// ****************************************************************
	// Registers
	// ****************************************************************
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			nmi_s1_reg <= 1'b0;
			nmi_s2_reg <= 1'b0;
			nmi_s3_reg <= 1'b0;
		end else begin
			nmi_s1_reg <= nmi_i;
			nmi_s2_reg <= nmi_s1_reg;
			nmi_s3_reg <= nmi_s2_reg;
		end
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			req_reg    <= 7'h00;
			ins_reg    <= 7'h00;
			sts_reg    <= 16'h0000;
			pend_q_reg <= 1'b0;
		end else begin
			req_reg    <= req_next;
			ins_reg    <= ins_next;
			sts_reg    <= sts_next;
			pend_q_reg <= pend_valid;
		end
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			mask_reg <= icu_pkg::MASK_RESET;
			pm_reg   <= icu_pkg::PM_RESET;
		end else begin
			if (wr_mask) begin
				mask_reg <= bus_i.wdata[6:0];
			end
			if (wr_pm) begin
				pm_reg <= bus_i.wdata[2:0];
			end
		end
	end

	// Read data stand only in the cycle after the strobe
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			rdata_reg <= 16'h0000;
		end else begin
			rdata_reg <= bus_i.rd ? rd_mux : 16'h0000;
		end
	end

	// Vector offered to the core only on the hardware path
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			ack_valid_reg <= 1'b0;
			ack_type_reg  <= 5'h00;
		end else begin
			ack_valid_reg <= hw_take;
			if (hw_take) begin
				ack_type_reg <= icu_pkg::src_type(pend_idx);
			end
		end
	end

	// ****************************************************************
	// Outputs
	// ****************************************************************
	assign rdata_o     = rdata_reg;
	assign int_pend_o  = pend_valid;
	assign ack_valid_o = ack_valid_reg;
	assign ack_type_o  = ack_type_reg;

endmodule : icu_poll_eoi
`default_nettype wire

// File: sim/icu_poll_eoi_assertions.sv
// Checker for the poll/EOI block, bound to its top module.
// Assumes one clock domain and the registered read port of the block.
`timescale 1ns/1ps
`default_nettype none
module icu_poll_eoi_assertions (
	input wire logic              clk_i,
	input wire logic              rst_n_i,
	input wire icu_pkg::icu_bus_t bus_i,
	input wire logic [15:0]       rdata_o,
	input wire logic              hw_ack_i,
	input wire logic              int_pend_o,
	input wire logic              ack_valid_o,
	input wire logic [4:0]        ack_type_o
);
	// ****************************************************************
	// Helpers
	// ****************************************************************
	wire logic poll_rd = bus_i.rd && bus_i.addr == icu_pkg::ADDR_POLL;
	wire logic hw_take = hw_ack_i && int_pend_o && !poll_rd;
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!rst_n_i);
	sequence s_poll_rd;
		poll_rd;
	endsequence
	sequence s_any_poll;
		bus_i.rd && bus_i.addr <= icu_pkg::ADDR_POLLSTS;
	endsequence
	// ****************************************************************
	// Properties
	// ****************************************************************
	chk_poll_no_vec: assert property (s_poll_rd |=> !ack_valid_o)
		else $error("poll read gave a vector pulse");
	chk_ack_answer: assert property (hw_take |=> ack_valid_o)
		else $error("hardware acknowledge not answered");
	chk_ack_cause: assert property (ack_valid_o |-> $past(hw_take))
		else $error("vector pulse without acknowledge");
	chk_type_hold: assert property (!ack_valid_o |-> $stable(ack_type_o))
		else $error("vector type moved without acknowledge");
	chk_poll_flag: assert property (s_any_poll |=> rdata_o[15] == $past(int_pend_o))
		else $error("poll pending flag wrong");
	chk_poll_shape: assert property (s_any_poll |=> rdata_o[14:5] == 10'h000 &&
		(rdata_o[15] ? rdata_o[4:0] != 5'h00 : rdata_o[4:0] == 5'h00))
		else $error("poll word layout wrong");
	chk_eos_rd_zero: assert property (bus_i.rd && bus_i.addr == icu_pkg::ADDR_EOS
		|=> rdata_o == 16'h0000)
		else $error("end-of-service register readable");
	chk_sts_pad: assert property (bus_i.rd && bus_i.addr == icu_pkg::ADDR_INTSTS
		|=> rdata_o[14:5] == 10'h000)
		else $error("status spare bits set");
	chk_rdata_idle: assert property (!bus_i.rd |=> rdata_o == 16'h0000)
		else $error("read data outside read answer");
endmodule : icu_poll_eoi_assertions
bind icu_poll_eoi icu_poll_eoi_assertions i_chk (.clk_i(clk_i), .rst_n_i(rst_n_i),
	.bus_i(bus_i), .rdata_o(rdata_o), .hw_ack_i(hw_ack_i), .int_pend_o(int_pend_o),
	.ack_valid_o(ack_valid_o), .ack_type_o(ack_type_o));
`default_nettype wire

// File: sim/icu_core_model.sv
// Core model: runs the hardware acknowledge handshake when enabled.
// Assumes the bench keeps it disabled while it polls over the bus.
`timescale 1ns/1ps
`default_nettype none
module icu_core_model (
	input  wire logic       clk_i,
	input  wire logic       rst_n_i,
	input  wire logic       en_i,
	input  wire logic [3:0] dly_i,
	input  wire logic       int_pend_i,
	input  wire logic       ack_valid_i,
	input  wire logic [4:0] ack_type_i,
	output logic            hw_ack_o,
	output logic [4:0]      last_type_o,
	output logic [3:0]      n_acks_o
);
	logic [3:0] wait_reg;
	// Slow answers stretch the wait before acknowledging
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			hw_ack_o    <= 1'b0;
			wait_reg    <= 4'h0;
			last_type_o <= 5'h00;
			n_acks_o    <= 4'h0;
		end else begin
			hw_ack_o <= 1'b0;
			if (en_i && int_pend_i && !hw_ack_o) begin
				if (wait_reg >= dly_i) begin
					hw_ack_o <= 1'b1;
					wait_reg <= 4'h0;
				end else begin
					wait_reg <= wait_reg + 4'h1;
				end
			end
			// Dispatch uses the type handed with the vector pulse
			if (ack_valid_i) begin
				last_type_o <= ack_type_i;
				n_acks_o    <= n_acks_o + 4'h1;
			end
		end
	end
endmodule : icu_core_model
`default_nettype wire

// File: sim/interrupt_poll_and_eoi_logic_bench.sv
// Self-checking bench for the poll/EOI block with a core model.
// Assumes the strobe register port and one 50 MHz clock.
`timescale 1ns/1ps
`default_nettype none
module interrupt_poll_and_eoi_logic_bench;
	logic clk_i = 1'b0, rst_n_i = 1'b0, nmi = 1'b0, nmi_ack = 1'b0, en = 1'b0;
	icu_pkg::icu_bus_t bus = '0;
	logic [4:0] ext = 5'h00, vt, ty;
	logic [2:0] tmr = 3'h0;
	logic [1:0] ser = 2'h0;
	logic [15:0] rdata;
	logic pend, avld, irq, hwack;
	logic [3:0] nacks;
	int mismatches = 0, n_checks = 0;
	icu_poll_eoi i_dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .bus_i(bus), .rdata_o(rdata),
		.ext_req_i(ext), .tmr_evt_i(tmr), .ser_evt_i(ser), .nmi_i(nmi), .nmi_ack_i(nmi_ack),
		.hw_ack_i(hwack), .int_pend_o(pend), .ack_valid_o(avld), .ack_type_o(vt), .irq_o(irq));
	icu_core_model i_core (.clk_i(clk_i), .rst_n_i(rst_n_i), .en_i(en), .dly_i(4'h3),
		.int_pend_i(pend), .ack_valid_i(avld), .ack_type_i(vt), .hw_ack_o(hwack),
		.last_type_o(ty), .n_acks_o(nacks));
	initial forever #10 clk_i = ~clk_i;
	// ****************************************************************
	// Tasks
	// ****************************************************************
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		n_checks++;
		if (seen !== exp) begin
			mismatches++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : chk
	task automatic wr(input logic [3:0] a, input logic [15:0] d);
		@(posedge clk_i);
		bus <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
		@(posedge clk_i);
		bus <= '0;
	endtask : wr
	task automatic rd(input logic [3:0] a, input logic [15:0] exp);
		@(posedge clk_i);
		bus <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 16'h0000};
		@(posedge clk_i);
		bus <= '0;
		#1 chk(rdata, exp);
	endtask : rd
	task automatic pulse(input logic [4:0] e, input logic [2:0] t, input logic [1:0] s);
		@(posedge clk_i);
		{ext, tmr, ser} <= {e, t, s};
		@(posedge clk_i);
		{ext, tmr, ser} <= '0;
	endtask : pulse
	task automatic irq_is(input logic exp);
		@(posedge clk_i);
		#1 chk({15'h0000, irq}, {15'h0000, exp});
	endtask : irq_is
	task automatic wrap_up;
		$display("checks %0d mismatches %0d", n_checks, mismatches);
		if (mismatches == 0 && n_checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : wrap_up
	// ****************************************************************
	// Tests
	// ****************************************************************
	initial begin
		#200000;
		mismatches++;
		wrap_up();
	end
	initial begin
		repeat (5) @(posedge clk_i);
		rst_n_i <= 1'b1;
		rd(icu_pkg::ADDR_PRIMSK, 16'h0007);
		rd(icu_pkg::ADDR_MASK, 16'h007F);
		chk({15'h0000, pend}, 16'h0000);
		pulse(5'h02, 3'h0, 2'h0);
		rd(icu_pkg::ADDR_REQST, 16'h0008);
		rd(icu_pkg::ADDR_POLL, 16'h0000);
		wr(icu_pkg::ADDR_MASK, 16'h0008);
		pulse(5'h01, 3'h1, 2'h0);
		rd(icu_pkg::ADDR_INTSTS, 16'h0001);
		rd(icu_pkg::ADDR_POLLSTS, 16'h8008);
		rd(icu_pkg::ADDR_POLLSTS, 16'h8008);
		rd(icu_pkg::ADDR_REQST, 16'h000D);
		rd(icu_pkg::ADDR_POLL, 16'h8008);
		rd(icu_pkg::ADDR_REQST, 16'h000C);
		rd(icu_pkg::ADDR_INSERV, 16'h0001);
		rd(icu_pkg::ADDR_INTSTS, 16'h0000);
		rd(icu_pkg::ADDR_POLLSTS, 16'h0000);
		wr(icu_pkg::ADDR_EOS, 16'h0008);
		rd(icu_pkg::ADDR_INSERV, 16'h0000);
		rd(icu_pkg::ADDR_POLLSTS, 16'h8011);
		// A threshold above the pending level hides it
		wr(icu_pkg::ADDR_PRIMSK, 16'h0001);
		rd(icu_pkg::ADDR_PRIMSK, 16'h0001);
		rd(icu_pkg::ADDR_POLLSTS, 16'h0000);
		chk({15'h0000, pend}, 16'h0000);
		wr(icu_pkg::ADDR_PRIMSK, 16'h0007);
		rd(icu_pkg::ADDR_POLLSTS, 16'h8011);
		chk({15'h0000, pend}, 16'h0001);
		@(posedge clk_i);
		en <= 1'b1;
		for (int i = 0; i < 40 && nacks == 4'h0; i++)
			@(posedge clk_i);
		en <= 1'b0;
		chk({11'h000, ty}, 16'h0011);
		rd(icu_pkg::ADDR_INSERV, 16'h0004);
		rd(icu_pkg::ADDR_REQST, 16'h0008);
		pulse(5'h00, 3'h6, 2'h1);
		rd(icu_pkg::ADDR_INTSTS, 16'h000E);
		rd(icu_pkg::ADDR_POLL, 16'h8008);
		rd(icu_pkg::ADDR_INSERV, 16'h0005);
		rd(icu_pkg::ADDR_INTSTS, 16'h000C);
		rd(icu_pkg::ADDR_POLL, 16'h0000);
		wr(icu_pkg::ADDR_EOS, 16'h8000);
		rd(icu_pkg::ADDR_INSERV, 16'h0004);
		rd(icu_pkg::ADDR_POLL, 16'h8014);
		rd(icu_pkg::ADDR_INSERV, 16'h0006);
		rd(icu_pkg::ADDR_INTSTS, 16'h0004);
		// A type that names no source clears nothing
		wr(icu_pkg::ADDR_EOS, 16'h001F);
		rd(icu_pkg::ADDR_INSERV, 16'h0006);
		wr(icu_pkg::ADDR_EOS, 16'h0011);
		rd(icu_pkg::ADDR_INSERV, 16'h0002);
		wr(icu_pkg::ADDR_EOS, 16'h8000);
		rd(icu_pkg::ADDR_INSERV, 16'h0000);
		wr(icu_pkg::ADDR_EVSTS, 16'h000F);
		wr(icu_pkg::ADDR_EVMASK, 16'h0004);
		wr(icu_pkg::ADDR_EOS, 16'h8000);
		irq_is(1'b1);
		rd(icu_pkg::ADDR_INSERV, 16'h0000);
		rd(icu_pkg::ADDR_REQST, 16'h0008);
		wr(icu_pkg::ADDR_EVMASK, 16'h0000);
		irq_is(1'b0);
		wr(icu_pkg::ADDR_EVMASK, 16'h0004);
		irq_is(1'b1);
		wr(icu_pkg::ADDR_EVSTS, 16'h0004);
		irq_is(1'b0);
		@(posedge clk_i);
		nmi <= 1'b1;
		repeat (5) @(posedge clk_i);
		rd(icu_pkg::ADDR_INTSTS, 16'h8004);
		@(posedge clk_i);
		nmi_ack <= 1'b1;
		@(posedge clk_i);
		nmi_ack <= 1'b0;
		rd(icu_pkg::ADDR_INTSTS, 16'h0004);
		wr(4'hF, 16'hFFFF);
		rd(4'hF, 16'h0000);
		rd(icu_pkg::ADDR_EOS, 16'h0000);
		wr(icu_pkg::ADDR_PRIMSK, 16'h0003);
		rd(icu_pkg::ADDR_PRIMSK, 16'h0003);
		// Reset in mid-run must bring back the PRIMSK, MASK, REQST, INSERV and INTSTS defaults and a low irq
		@(posedge clk_i);
		nmi     <= 1'b0;
		rst_n_i <= 1'b0;
		repeat (5) @(posedge clk_i);
		rst_n_i <= 1'b1;
		rd(icu_pkg::ADDR_PRIMSK, 16'h0007);
		rd(icu_pkg::ADDR_MASK, 16'h007F);
		rd(icu_pkg::ADDR_REQST, 16'h0000);
		rd(icu_pkg::ADDR_INSERV, 16'h0000);
		rd(icu_pkg::ADDR_INTSTS, 16'h0000);
		irq_is(1'b0);
		wrap_up();
	end
endmodule : interrupt_poll_and_eoi_logic_bench
`default_nettype wire
